// [verilog/vgc_consts.svh]
// Port addresses, register indexes, field positions and reset values
`ifndef VGC_CONSTS_SVH
`define VGC_CONSTS_SVH
`define VGC_PORT_ATTR_W     16'h03c0
`define VGC_PORT_ATTR_R     16'h03c1
`define VGC_PORT_SEQ_IDX    16'h03c4
`define VGC_PORT_SEQ_DAT    16'h03c5
`define VGC_PORT_GFX_IDX    16'h03ce
`define VGC_PORT_GFX_DAT    16'h03cf
`define VGC_PORT_STAT1_MONO 16'h03ba
`define VGC_PORT_STAT1_COL  16'h03da
`define VGC_GI_SET_RESET    4'h0
`define VGC_GI_EN_SR        4'h1
`define VGC_GI_CMP          4'h2
`define VGC_GI_ROTATE       4'h3
`define VGC_GI_MAP_SEL      4'h4
`define VGC_GI_MODE         4'h5
`define VGC_GI_MISC         4'h6
`define VGC_GI_DONT_CARE    4'h7
`define VGC_GI_MASK         4'h8
`define VGC_AI_MODE         5'h10
`define VGC_AI_BORDER       5'h11
`define VGC_AI_PLANE_EN     5'h12
`define VGC_AI_PAN          5'h13
`define VGC_AI_CSEL         5'h14
`define VGC_SI_RESET        8'h00
`define VGC_SI_CLK_MODE     8'h01
`define VGC_GM_READ_MODE    3
`define VGC_GM_SHIFT256     6
`define VGC_MISC_ODD_EVEN   1
`define VGC_AMC_UPPER_SEL   7
`define VGC_AMC_PIX_WIDTH   6
`define VGC_AIDX_PAL_SRC    5
`define VGC_CM_SCREEN_OFF   5
`define VGC_CM_LOAD4        4
`define VGC_CM_DOT_DIV2     3
`define VGC_CM_SHIFT_LOAD   2
`define VGC_CM_DOT8         0
`define VGC_RST_SYNC        1
`define VGC_RST_ASYNC       0
`define VGC_SEQ_RESET_RST   2'h3
`define VGC_MASK_RST        8'hff
`define VGC_MM_128K_A0      2'h0
`define VGC_MM_64K_A0       2'h1
`define VGC_MM_32K_B0       2'h2
`define VGC_MM_32K_B8       2'h3
`endif

// [verilog/vgc_pkg.sv]
// Types shared by the graphics controller registers and the write datapath
package vgc_pkg;
  typedef enum logic [1:0] {
    VGC_FN_MOVE = 2'b00,
    VGC_FN_AND  = 2'b01,
    VGC_FN_OR   = 2'b10,
    VGC_FN_XOR  = 2'b11
  } vgc_func_t;
  typedef enum logic [1:0] {
    VGC_WM_CPU   = 2'b00,
    VGC_WM_LATCH = 2'b01,
    VGC_WM_FILL  = 2'b10,
    VGC_WM_SR    = 2'b11
  } vgc_wmode_t;
  typedef struct packed {
    logic [3:0] set_reset;
    logic [3:0] en_sr;
    vgc_func_t  func;
    logic [2:0] rot;
    vgc_wmode_t wmode;
    logic [7:0] mask;
  } vgc_wr_cfg_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] color;
  } vgc_pix_t;
endpackage

// [verilog/vgc_fifo.sv]
// Single-clock FIFO with valid/ready on both sides
`timescale 1ns/1ps
module vgc_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_resetn,
  input  wire logic             i_flush,
  input  wire logic             i_valid,
  output logic                  o_ready,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_valid,
  input  wire logic             i_ready,
  output logic      [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
    $error("vgc_fifo: DEPTH must be a power of two >= 2");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      rp_q;
  wire              push = i_valid && o_ready;
  wire              pop  = o_valid && i_ready;
  assign o_ready = (wp_q - rp_q) != (AW+1)'(DEPTH);
  assign o_valid = wp_q != rp_q;
  assign o_data  = mem_q[rp_q[AW-1:0]];
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= i_data;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn || i_flush) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_q + (AW+1)'(push);
      rp_q <= rp_q + (AW+1)'(pop);
    end
  end
endmodule

// [verilog/vgc_wr_alu.sv]
// Write datapath: rotate, set/reset, logic function and bit mask per map
`timescale 1ns/1ps
module vgc_wr_alu
  import vgc_pkg::*;
(
  input  wire vgc_wr_cfg_t i_cfg,
  input  wire logic [7:0]  i_cpu,
  input  wire logic [31:0] i_latch,
  output logic      [31:0] o_data
);
  wire [15:0] dbl = {i_cpu, i_cpu};
  wire [7:0]  rot = dbl[i_cfg.rot +: 8];
  wire [7:0]  bmask = (i_cfg.wmode == VGC_WM_SR) ? (rot & i_cfg.mask)
                                                 : i_cfg.mask;
  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_map
      wire [7:0] lat = i_latch[8*p +: 8];
      logic [7:0] src;
      logic [7:0] alu;
      always_comb begin
        case (i_cfg.wmode)
          VGC_WM_CPU:   src = i_cfg.en_sr[p] ? {8{i_cfg.set_reset[p]}}
                                             : rot;
          VGC_WM_FILL:  src = {8{i_cpu[p]}};
          VGC_WM_SR:    src = {8{i_cfg.set_reset[p]}};
          default:      src = lat;
        endcase
        case (i_cfg.func)
          VGC_FN_AND: alu = src & lat;
          VGC_FN_OR:  alu = src | lat;
          VGC_FN_XOR: alu = src ^ lat;
          default:    alu = src;
        endcase
      end
      // Latch mode copies the latches whole; mask and function do not apply
      assign o_data[8*p +: 8] = (i_cfg.wmode == VGC_WM_LATCH) ? lat
                              : (alu & bmask) | (lat & ~bmask);
    end
  endgenerate
endmodule

// [verilog/vgc_regs.sv]
// Graphics controller, attribute controller and sequencer control logic
`timescale 1ns/1ps
`include "vgc_consts.svh"
module vgc_regs
  import vgc_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  input  wire logic        i_io_wr,
  input  wire logic        i_io_rd,
  input  wire logic [15:0] i_io_addr,
  input  wire logic [7:0]  i_io_wdata,
  output logic      [7:0]  o_io_rdata,
  input  wire logic        i_mem_wr,
  input  wire logic        i_mem_rd,
  input  wire logic [19:0] i_mem_addr,
  input  wire logic [7:0]  i_mem_wdata,
  input  wire logic        i_chain4,
  input  wire logic        i_oe_page,
  input  wire logic [3:0]  i_map_enable,
  input  wire logic        i_map_rvalid,
  input  wire logic [31:0] i_map_rdata,
  output logic             o_map_wr,
  output logic             o_map_rd,
  output logic      [3:0]  o_map_wen,
  output logic      [16:0] o_map_addr,
  output logic      [31:0] o_map_wdata,
  output logic             o_mem_rvalid,
  output logic      [7:0]  o_mem_rdata,
  input  wire logic        i_pix_valid,
  input  wire logic [3:0]  i_pix_idx,
  output logic             o_pix_ready,
  output logic             o_pix_valid,
  output logic      [7:0]  o_pix_color,
  input  wire logic        i_vretrace,
  input  wire logic        i_disp_off,
  input  wire logic        i_char_tick,
  input  wire logic        i_video_pixel_clock_tick,
  input  wire logic        i_fetch_req,
  output logic             o_fetch_req,
  output logic             o_ser_load,
  output logic             o_dot_en,
  output logic      [1:0]  o_shift_mode,
  output logic      [4:0]  o_pan_half,
  output logic             o_timing_halt,
  output logic             o_seq_halt
);
  if (FIFO_DEPTH != 8) begin : g_depth_chk
    $error("vgc_regs: pixel buffer is sized for 8 entries");
  end

  // Graphics controller registers
  logic [3:0] gidx_q, sr_q, esr_q, cmp_q, dc_q, misc_q;
  logic [4:0] rot_q;
  logic [1:0] rms_q;
  logic [6:0] gmode_q;
  logic [7:0] mask_q;
  // Attribute controller registers
  logic       aff_q;
  logic [5:0] aidx_q;
  logic [5:0] pal_q [16];
  logic [7:0] amc_q, border_q;
  logic [5:0] pen_q;
  logic [3:0] pan_q, csel_q;
  // Sequencer registers
  logic [7:0] sidx_q;
  logic [1:0] srst_q;
  logic [5:0] clkm_q;
  // Memory side and display timing state
  logic [31:0] latch_q;
  logic [1:0]  rsel_q;
  logic        rcmp_q;
  logic [1:0]  chr_q;
  logic        dot_q;
  logic        pw_q;

  // Host port decode
  wire wr_attr = i_io_wr && i_io_addr == `VGC_PORT_ATTR_W;
  wire wr_sidx = i_io_wr && i_io_addr == `VGC_PORT_SEQ_IDX;
  wire wr_sdat = i_io_wr && i_io_addr == `VGC_PORT_SEQ_DAT;
  wire wr_gidx = i_io_wr && i_io_addr == `VGC_PORT_GFX_IDX;
  wire wr_gdat = i_io_wr && i_io_addr == `VGC_PORT_GFX_DAT;
  wire rd_stat = i_io_rd && (i_io_addr == `VGC_PORT_STAT1_MONO ||
                             i_io_addr == `VGC_PORT_STAT1_COL);
  wire wr_aidx = wr_attr && !aff_q;
  wire wr_adat = wr_attr && aff_q;
  wire [4:0] aix = aidx_q[4:0];

  // Write side configuration for the datapath
  vgc_wr_cfg_t wcfg;
  assign wcfg.set_reset = sr_q;
  assign wcfg.en_sr     = esr_q;
  assign wcfg.func      = vgc_func_t'(rot_q[4:3]);
  assign wcfg.rot       = rot_q[2:0];
  assign wcfg.wmode     = vgc_wmode_t'(gmode_q[1:0]);
  assign wcfg.mask      = mask_q;

  // Window decode and map addressing
  wire [1:0] mm = misc_q[3:2];
  logic       hit;
  logic [16:0] off;
  always_comb begin
    case (mm)
      `VGC_MM_128K_A0: begin
        hit = i_mem_addr[19:17] == 3'h5;
        off = i_mem_addr[16:0];
      end
      `VGC_MM_64K_A0: begin
        hit = i_mem_addr[19:16] == 4'ha;
        off = {1'b0, i_mem_addr[15:0]};
      end
      `VGC_MM_32K_B0: begin
        hit = i_mem_addr[19:15] == 5'h16;
        off = {2'h0, i_mem_addr[14:0]};
      end
      default: begin
        hit = i_mem_addr[19:15] == 5'h17;
        off = {2'h0, i_mem_addr[14:0]};
      end
    endcase
  end
  wire oe_mode = misc_q[`VGC_MISC_ODD_EVEN] && !i_chain4;
  wire cpu_addr_bit_zero = off[0];
  wire [16:0] map_addr = oe_mode ? {off[16:1], i_oe_page} : off;
  wire [3:0] oe_maps = cpu_addr_bit_zero ? 4'ha : 4'h5;
  wire [3:0] c4_maps = 4'h1 << off[1:0];
  wire [3:0] wmaps = i_map_enable & (i_chain4 ? c4_maps :
                                     oe_mode ? oe_maps : 4'hf);
  wire [1:0] rsel = i_chain4 ? off[1:0] :
                    oe_mode ? {rms_q[1], cpu_addr_bit_zero} : rms_q;
  wire rcmp = gmode_q[`VGC_GM_READ_MODE] && !i_chain4;
  wire [31:0] wdata;

  vgc_wr_alu u_alu (
    .i_cfg   (wcfg),
    .i_cpu   (i_mem_wdata),
    .i_latch (latch_q),
    .o_data  (wdata)
  );

  // Colour compare across the four maps
  wire  [7:0] cmp_res;
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_cmp
      wire [3:0] bits = {i_map_rdata[24+b], i_map_rdata[16+b],
                         i_map_rdata[8+b], i_map_rdata[b]};
      assign cmp_res[b] = &(~dc_q | ~(bits ^ cmp_q));
    end
  endgenerate
  wire [7:0] map_byte = i_map_rdata[8*rsel_q +: 8];
  wire [7:0] rd_byte  = rcmp_q ? cmp_res : map_byte;

  // Host read data
  logic [7:0] gdat, adat, sdat;
  always_comb begin
    case (gidx_q)
      `VGC_GI_SET_RESET: gdat = {4'h0, sr_q};
      `VGC_GI_EN_SR:     gdat = {4'h0, esr_q};
      `VGC_GI_CMP:       gdat = {4'h0, cmp_q};
      `VGC_GI_ROTATE:    gdat = {3'h0, rot_q};
      `VGC_GI_MAP_SEL:   gdat = {6'h0, rms_q};
      `VGC_GI_MODE:      gdat = {1'b0, gmode_q};
      `VGC_GI_MISC:      gdat = {4'h0, misc_q};
      `VGC_GI_DONT_CARE: gdat = {4'h0, dc_q};
      `VGC_GI_MASK:      gdat = mask_q;
      default:           gdat = 8'h00;
    endcase
    case (aix)
      `VGC_AI_MODE:     adat = amc_q;
      `VGC_AI_BORDER:   adat = border_q;
      `VGC_AI_PLANE_EN: adat = {2'h0, pen_q};
      `VGC_AI_PAN:      adat = {4'h0, pan_q};
      `VGC_AI_CSEL:     adat = {4'h0, csel_q};
      default:          adat = aix[4] ? 8'h00 : {2'h0, pal_q[aix[3:0]]};
    endcase
    case (sidx_q)
      `VGC_SI_RESET:    sdat = {6'h0, srst_q};
      `VGC_SI_CLK_MODE: sdat = {2'h0, clkm_q};
      default:          sdat = 8'h00;
    endcase
  end
  // Two of the eight colour outputs reach status bits 5:4
  wire [7:0] c = o_pix_color;
  wire [1:0] vstat = (pen_q[5:4] == 2'h0) ? {c[2], c[0]} :
                     (pen_q[5:4] == 2'h1) ? {c[5], c[4]} :
                     (pen_q[5:4] == 2'h2) ? {c[3], c[1]} :
                                            {c[7], c[6]};
  wire [7:0] stat1 = {2'h0, vstat, i_vretrace, 2'h0, i_disp_off};
  wire [7:0] io_rd =
      (i_io_addr == `VGC_PORT_ATTR_W)  ? {2'h0, aidx_q} :
      (i_io_addr == `VGC_PORT_ATTR_R)  ? adat :
      (i_io_addr == `VGC_PORT_SEQ_IDX) ? sidx_q :
      (i_io_addr == `VGC_PORT_SEQ_DAT) ? sdat :
      (i_io_addr == `VGC_PORT_GFX_IDX) ? {4'h0, gidx_q} :
      (i_io_addr == `VGC_PORT_GFX_DAT) ? gdat :
      rd_stat                          ? stat1 : 8'h00;

  // Register writes
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      gidx_q <= 4'h0; sr_q <= 4'h0; esr_q <= 4'h0; cmp_q <= 4'h0;
      rot_q <= 5'h00; rms_q <= 2'h0; gmode_q <= 7'h00;
      misc_q <= 4'h0; dc_q <= 4'h0; mask_q <= `VGC_MASK_RST;
    end else if (wr_gidx) begin
      gidx_q <= i_io_wdata[3:0];
    end else if (wr_gdat) begin
      case (gidx_q)
        `VGC_GI_SET_RESET: sr_q    <= i_io_wdata[3:0];
        `VGC_GI_EN_SR:     esr_q   <= i_io_wdata[3:0];
        `VGC_GI_CMP:       cmp_q   <= i_io_wdata[3:0];
        `VGC_GI_ROTATE:    rot_q   <= i_io_wdata[4:0];
        `VGC_GI_MAP_SEL:   rms_q   <= i_io_wdata[1:0];
        `VGC_GI_MODE:      gmode_q <= {i_io_wdata[6:3], 1'b0,
                                       i_io_wdata[1:0]};
        `VGC_GI_MISC:      misc_q  <= i_io_wdata[3:0];
        `VGC_GI_DONT_CARE: dc_q    <= i_io_wdata[3:0];
        `VGC_GI_MASK:      mask_q  <= i_io_wdata;
        default:           mask_q  <= mask_q;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      aff_q <= 1'b0;
    end else if (wr_attr) begin
      aff_q <= !aff_q;
    end else if (rd_stat) begin
      aff_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      aidx_q <= 6'h00; amc_q <= 8'h00; border_q <= 8'h00;
      pen_q <= 6'h00; pan_q <= 4'h0; csel_q <= 4'h0;
    end else if (wr_aidx) begin
      aidx_q <= i_io_wdata[5:0];
    end else if (wr_adat) begin
      case (aix)
        `VGC_AI_MODE:     amc_q    <= {i_io_wdata[7:5], 1'b0,
                                       i_io_wdata[3:0]};
        `VGC_AI_BORDER:   border_q <= i_io_wdata;
        `VGC_AI_PLANE_EN: pen_q    <= i_io_wdata[5:0];
        `VGC_AI_PAN:      pan_q    <= i_io_wdata[3:0];
        `VGC_AI_CSEL:     csel_q   <= i_io_wdata[3:0];
        default:          csel_q   <= csel_q;
      endcase
    end
  end

  // Palette has no reset; software loads it before enabling output
  always_ff @(posedge i_clk_sys) begin
    if (wr_adat && !aix[4]) begin
      pal_q[aix[3:0]] <= i_io_wdata[5:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      sidx_q <= 8'h00; srst_q <= `VGC_SEQ_RESET_RST; clkm_q <= 6'h00;
    end else if (wr_sidx) begin
      sidx_q <= i_io_wdata;
    end else if (wr_sdat && sidx_q == `VGC_SI_RESET) begin
      srst_q <= i_io_wdata[1:0];
    end else if (wr_sdat && sidx_q == `VGC_SI_CLK_MODE) begin
      clkm_q <= {i_io_wdata[5:2], 1'b0, i_io_wdata[0]};
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_io_rdata <= 8'h00;
    end else if (i_io_rd) begin
      o_io_rdata <= io_rd;
    end
  end

  // Memory requests: one cycle to the map port, reads return on rvalid
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_map_wr <= 1'b0; o_map_rd <= 1'b0; o_map_wen <= 4'h0;
      o_map_addr <= 17'h00000; o_map_wdata <= 32'h0;
      rsel_q <= 2'h0; rcmp_q <= 1'b0;
    end else begin
      o_map_wr  <= i_mem_wr && hit;
      o_map_rd  <= i_mem_rd && hit && !i_mem_wr;
      o_map_wen <= (i_mem_wr && hit) ? wmaps : 4'h0;
      if (hit && (i_mem_wr || i_mem_rd)) begin
        o_map_addr <= map_addr;
      end
      if (i_mem_wr && hit) begin
        o_map_wdata <= wdata;
      end
      if (i_mem_rd && hit && !i_mem_wr) begin
        rsel_q <= rsel;
        rcmp_q <= rcmp;
      end
    end
  end

  // Every read refreshes all four latches, which masked writes reuse
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      latch_q <= 32'h0; o_mem_rvalid <= 1'b0; o_mem_rdata <= 8'h00;
    end else begin
      o_mem_rvalid <= i_map_rvalid;
      if (i_map_rvalid) begin
        latch_q     <= i_map_rdata;
        o_mem_rdata <= rd_byte;
      end
    end
  end

  // Attribute pixel path behind the buffer
  wire       buf_valid;
  wire       buf_not_full;
  wire [3:0] buf_idx;
  wire       halted = !srst_q[`VGC_RST_ASYNC];
  wire       scr_off = clkm_q[`VGC_CM_SCREEN_OFF];
  wire       pix_slot = !amc_q[`VGC_AMC_PIX_WIDTH] || pw_q;
  wire       drain = buf_valid && pix_slot && !halted;
  wire [3:0] pidx = buf_idx & pen_q[3:0];
  wire [5:0] pal = pal_q[pidx];
  wire       m256 = gmode_q[`VGC_GM_SHIFT256];
  wire [1:0] up = amc_q[`VGC_AMC_UPPER_SEL] ? csel_q[1:0]
                                            : pal[5:4];
  wire [1:0] top = m256 ? 2'h0 : csel_q[3:2];
  wire [7:0] color = !aidx_q[`VGC_AIDX_PAL_SRC] ? border_q :
                     {top, up, pal[3:0]};

  vgc_fifo #(
    .WIDTH (4),
    .DEPTH (FIFO_DEPTH)
  ) u_buf (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_flush   (halted),
    .i_valid   (i_pix_valid),
    .o_ready   (buf_not_full),
    .i_data    (i_pix_idx),
    .o_valid   (buf_valid),
    .i_ready   (drain),
    .o_data    (buf_idx)
  );
  wire buf_ready_now = buf_not_full && !halted;

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      pw_q <= 1'b0; o_pix_valid <= 1'b0; o_pix_color <= 8'h00;
      o_pix_ready <= 1'b0;
    end else begin
      pw_q        <= halted ? 1'b0 : !pw_q;
      o_pix_valid <= drain;
      o_pix_color <= (drain && !scr_off) ? color : 8'h00;
      o_pix_ready <= buf_ready_now;
    end
  end

  // Panning shift in half pixels; codes 8-15 mean one pixel right, or no shift in 9-dot text mode
  wire dot9 = !clkm_q[`VGC_CM_DOT8];
  wire [4:0] pan_lo = {1'b0, pan_q};
  wire [4:0] pan_half = pan_q[3] ? (dot9 && !m256 ? 5'h00 : 5'h1e) :
                        m256 ? pan_lo :
                        dot9 ? 5'((pan_lo + 5'h01) << 1) :
                               5'(pan_lo << 1);

  // Serializer load and dot clock cadence
  wire load4 = clkm_q[`VGC_CM_LOAD4];
  wire ser_load = i_char_tick &&
                  (load4 ? chr_q == 2'h0 :
                   clkm_q[`VGC_CM_SHIFT_LOAD] ? !chr_q[0] : 1'b1);

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      chr_q <= 2'h0; dot_q <= 1'b0; o_ser_load <= 1'b0; o_dot_en <= 1'b0;
      o_fetch_req <= 1'b0; o_shift_mode <= 2'h0; o_pan_half <= 5'h00;
      o_timing_halt <= 1'b0; o_seq_halt <= 1'b0;
    end else begin
      chr_q <= halted ? 2'h0 : chr_q + 2'(i_char_tick);
      if (i_video_pixel_clock_tick) begin
        dot_q <= !dot_q;
      end
      o_ser_load    <= ser_load && !halted;
      o_dot_en      <= i_video_pixel_clock_tick &&
                       (!clkm_q[`VGC_CM_DOT_DIV2] || dot_q);
      o_fetch_req   <= i_fetch_req && !scr_off && !halted;
      o_shift_mode  <= gmode_q[6:5];
      o_pan_half    <= pan_half;
      o_timing_halt <= !srst_q[`VGC_RST_SYNC];
      o_seq_halt    <= halted;
    end
  end
endmodule

// [bench/vgc_regs_monitor.sv]
// Port-level assertions for the VGA control block
`timescale 1ns/1ps
module vgc_regs_monitor (
  input logic       i_clk_sys,
  input logic       i_resetn,
  input logic       i_mem_wr,
  input logic       i_mem_rd,
  input logic       i_map_rvalid,
  input logic       i_fetch_req,
  input logic       o_map_wr,
  input logic       o_map_rd,
  input logic       o_mem_rvalid,
  input logic       o_pix_valid,
  input logic       o_fetch_req,
  input logic       o_seq_halt,
  input logic [3:0] o_map_wen,
  input logic [7:0] o_pix_color,
  input logic [4:0] o_pan_half
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  sequence rd_ack;
    i_map_rvalid ##1 o_mem_rvalid;
  endsequence
  map_wr_a: assert property (o_map_wr |-> $past(i_mem_wr))
    else $error("map write without host write");
  map_rd_a: assert property (o_map_rd |-> $past(i_mem_rd)
    && !$past(i_mem_wr)) else $error("map read without host read");
  rd_return_a: assert property (i_map_rvalid |-> rd_ack)
    else $error("read data not returned");
  wen_idle_a: assert property (!o_map_wr |-> o_map_wen == 4'h0)
    else $error("write enables outside a write");
  color_idle_a: assert property (
    !o_pix_valid |-> o_pix_color == 8'h00)
    else $error("pixel colour outside a pixel");
  fetch_gate_a: assert property (o_fetch_req |-> $past(i_fetch_req))
    else $error("fetch request without a source request");
  halt_drain_a: assert property (o_seq_halt [*2] |-> !o_pix_valid)
    else $error("pixel drained while halted");
  pan_range_a: assert property (
    o_pan_half inside {[5'h00:5'h10], 5'h1e})
    else $error("panning shift out of range");
  rst_quiet_a: assert property (!$past(i_resetn) |-> !o_map_wr)
    else $error("map write right after reset");
endmodule
bind vgc_regs vgc_regs_monitor mon_u (.*);

// [bench/vgc_map_model.sv]
// Behavioural map memory answering the block's map reads
`timescale 1ns/1ps
module vgc_map_model (
  input  logic        i_clk_sys,
  input  logic        i_rd,
  input  logic        i_slow,
  output logic        o_rvalid = 1'b0,
  output logic [31:0] o_rdata = 32'h0
);
  logic [2:0] dly_q = 3'h0;
  // Outside the answer cycle the data shows its inverse, never stale data
  always @(posedge i_clk_sys) begin
    dly_q <= i_rd ? 3'h1 : (dly_q != 3'h0 ? dly_q + 3'h1 : 3'h0);
    o_rvalid <= dly_q == (i_slow ? 3'h3 : 3'h2);
    o_rdata <= dly_q == (i_slow ? 3'h3 : 3'h2) ? 32'h44332211 : 32'hbbccddee;
  end
endmodule

// [bench/vgc_regs_test.sv]
// Self-checking bench for the VGA control block
`timescale 1ns/1ps
module vgc_regs_test;
  logic i_clk_sys = 0, i_resetn = 0, i_io_wr = 0, i_io_rd = 0, slow = 0;
  logic i_mem_wr = 0, i_mem_rd = 0, i_pix_valid = 0, i_fetch_req = 0;
  logic i_char_tick = 0, i_video_pixel_clock_tick = 0, i_chain4 = 0;
  logic i_oe_page = 0, i_vretrace = 0, i_disp_off = 0;
  logic [15:0] i_io_addr = 0;
  logic [19:0] i_mem_addr = 0;
  logic [7:0]  i_io_wdata = 0, i_mem_wdata = 0, rd;
  logic [3:0]  i_pix_idx = 0, i_map_enable = 4'hf;
  wire i_map_rvalid, o_map_wr, o_map_rd, o_mem_rvalid, o_pix_ready;
  wire o_pix_valid, o_fetch_req, o_ser_load, o_dot_en;
  wire o_timing_halt, o_seq_halt;
  wire [31:0] i_map_rdata, o_map_wdata;
  wire [7:0]  o_io_rdata, o_mem_rdata, o_pix_color;
  wire [3:0]  o_map_wen;
  wire [16:0] o_map_addr;
  wire [1:0]  o_shift_mode;
  wire [4:0]  o_pan_half;
  int n_mismatch = 0, samples_checked = 0, cyc = 0;
  vgc_regs dut_u (.*);
  vgc_map_model pm_u (.i_clk_sys(i_clk_sys), .i_rd(o_map_rd),
    .i_slow(slow), .o_rvalid(i_map_rvalid), .o_rdata(i_map_rdata));
  initial forever #50 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    i_char_tick <= ~i_char_tick;
    i_video_pixel_clock_tick <= ~i_video_pixel_clock_tick;
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_io_wr <= w;
    i_io_rd <= !w;
    i_io_addr <= a;
    i_io_wdata <= d;
    @(posedge i_clk_sys);
    i_io_wr <= 0;
    i_io_rd <= 0;
    @(posedge i_clk_sys) #1;
    rd = o_io_rdata;
  endtask
  task automatic gw(input logic [3:0] i, input logic [7:0] d);
    io(1, 16'h03ce, {4'h0, i});
    io(1, 16'h03cf, d);
  endtask
  task automatic mem(input logic w, input logic [19:0] a, input logic [7:0] d);
    int i;
    @(posedge i_clk_sys);
    i_mem_wr <= w;
    i_mem_rd <= !w;
    i_mem_addr <= a;
    i_mem_wdata <= d;
    @(posedge i_clk_sys);
    i_mem_wr <= 0;
    i_mem_rd <= 0;
    #1;
    for (i = 0; i < 8 && (w ? o_map_wr : o_mem_rvalid) !== 1'b1; i++)
      @(posedge i_clk_sys) #1;
    chk(w ? o_map_wr : o_mem_rvalid, 1);
  endtask
  task automatic t_regs;
    io(1, 16'h03ce, 8'h08);
    io(0, 16'h03cf, 0);
    chk(rd, 8'hff);
    io(1, 16'h03c4, 0);
    io(0, 16'h03c5, 0);
    chk(rd, 8'h03);
  endtask
  task automatic t_attr;
    io(0, 16'h03da, 0);
    io(1, 16'h03c0, 8'h11);
    io(1, 16'h03c0, 8'h5a);
    io(0, 16'h03c1, 0);
    chk(rd, 8'h5a);
    pix(4'h3, 8'h5a);
  endtask
  task automatic t_write;
    gw(8, 8'h0f);
    mem(1, 20'ha0000, 8'hff);
    chk(o_map_wdata, 32'h0f0f0f0f);
    chk(o_map_wen, 4'hf);
    gw(8, 8'hff);
    gw(3, 8'h01);
    mem(1, 20'ha0000, 8'h01);
    chk(o_map_wdata, 32'h80808080);
  endtask
  task automatic t_read;
    gw(4, 8'h02);
    slow = 1;
    mem(0, 20'ha0005, 0);
    chk(o_mem_rdata, 8'h33);
    gw(3, 8'h19);
    mem(1, 20'ha0000, 8'h01);
    chk(o_map_wdata, 32'hc4b3a291);
  endtask
  task automatic t_seq;
    @(posedge i_clk_sys);
    i_fetch_req <= 1;
    io(1, 16'h03c4, 8'h01);
    io(1, 16'h03c5, 8'h20);
    chk(o_fetch_req, 0);
    io(1, 16'h03c5, 8'h00);
    chk(o_fetch_req, 1);
    io(1, 16'h03c4, 8'h00);
    io(1, 16'h03c5, 8'h00);
    chk({o_timing_halt, o_seq_halt, o_pix_ready}, 3'h6);
    io(1, 16'h03c5, 8'h03);
  endtask
  task automatic aw(input logic [7:0] i, input logic [7:0] d);
    io(1, 16'h03c0, i);
    io(1, 16'h03c0, d);
  endtask
  task automatic pix(input logic [3:0] x, input logic [7:0] e);
    int i;
    @(posedge i_clk_sys);
    i_pix_valid <= 1;
    i_pix_idx <= x;
    @(posedge i_clk_sys);
    i_pix_valid <= 0;
    #1;
    for (i = 0; i < 8 && o_pix_valid !== 1'b1; i++) @(posedge i_clk_sys) #1;
    chk(o_pix_color, e);
  endtask
  task automatic t_modes;
    int n, m;
    gw(0, 8'h05);
    gw(1, 8'h0f);
    gw(3, 8'h00);
    mem(1, 20'ha0123, 8'h00);
    chk(o_map_wdata, 32'h00ff00ff);
    chk(o_map_addr, 17'h00123);
    gw(5, 8'h63);
    mem(1, 20'ha0000, 8'hf0);
    chk(o_map_wdata, 32'h04f302f1);
    chk(o_shift_mode, 2'h3);
    gw(5, 8'h42);
    mem(1, 20'ha0000, 8'h0a);
    chk(o_map_wdata, 32'hff00ff00);
    chk(o_shift_mode, 2'h2);
    gw(2, 8'h01);
    gw(7, 8'h0b);
    gw(5, 8'h08);
    mem(0, 20'ha0000, 8'h00);
    chk(o_mem_rdata, 8'h11);
    gw(6, 8'h0e);
    mem(1, 20'hb8125, 8'h00);
    chk(o_map_addr, 17'h00124);
    chk(o_map_wen, 4'ha);
    aw(8'h23, 8'h2a);
    aw(8'h32, 8'h0f);
    aw(8'h34, 8'h0c);
    aw(8'h33, 8'h05);
    chk(o_pan_half, 5'h0c);
    pix(4'h3, 8'hea);
    io(1, 16'h03c4, 8'h01);
    io(1, 16'h03c5, 8'h18);
    n = 0;
    m = 0;
    repeat (16) begin
      @(posedge i_clk_sys) #1;
      n += o_ser_load;
      m += o_dot_en;
    end
    chk(n, 2);
    chk(m, 4);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge i_clk_sys);
    i_resetn <= 1;
    t_regs();
    t_attr();
    t_write();
    t_read();
    t_seq();
    t_modes();
    give_verdict();
  end
endmodule
